/* File: src/adcctl_clkgen.sv */
/*
  Conversion bit-period tick generator: one-cycle tick per bit period
  for the selected division of the core clock or the internal rc rate.
  Assumes run is high only during a conversion or its abort, which may follow a clear of the enable.
*/
module adcctl_clkgen
  import adcctl_pkg::*;
#(
  parameter int RC_DIVIDE = RC_DIV
) (
  input wire logic clk, // core clock
  input wire logic rst_n, // synchronised reset
  input wire logic run, // counting allowed
  input wire logic [1:0] sel, // conversion clock select
  output logic tick // one bit period elapsed
);
  initial begin
    if (RC_DIVIDE < 2 || RC_DIVIDE > 65536) begin
      $error("rc divide out of range");
    end
  end

  // sixteen bits so the default rc division still fits the counter
  logic [15:0] cnt_q, cnt_d;
  logic [15:0] last;

  // ------------------------------------------------------------
  // divisor for the chosen source
  // ------------------------------------------------------------
  assign last = (sel == CLK_DIV2) ? 16'(SYS_DIV2 - 1) :
                (sel == CLK_DIV8) ? 16'(SYS_DIV8 - 1) :
                (sel == CLK_DIV32) ? 16'(SYS_DIV32 - 1) :
                16'(RC_DIVIDE - 1);
  assign tick = run && (cnt_q >= last);
  assign cnt_d = (!run || tick) ? 16'h0000 : cnt_q + 16'h0001;

  // divider counter, held at zero while idle for a clean first period
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule // adcctl_clkgen

/* File: src/adcctl_format.sv */
/*
  Result formatter: spreads a 10-bit result over two bytes, left or
  right justified. Reserved bits are driven as zero.
  Assumes the result input is stable while the bytes are loaded.
*/
module adcctl_format (
  input wire logic [9:0] result, // conversion result
  input wire logic right_just, // one selects right justified
  output logic [7:0] high_byte, // result high byte
  output logic [7:0] low_byte // result low byte
);
  // ------------------------------------------------------------
  // justification select
  // ------------------------------------------------------------
  assign high_byte = right_just ? {6'h00, result[9:8]} :
                     result[9:2];
  assign low_byte = right_just ? result[7:0] :
                    {result[1:0], 6'h00};
endmodule // adcctl_format

/* File: src/adcctl_pkg.sv */
/*
  Constants shared by the converter control block: register offsets,
  field positions, reset values and timing counts.
  Assumes an 8-bit register port with word-indexed offsets.
*/
package adcctl_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [1:0] OFS_CTRL_PRI = 2'h0;
  localparam logic [1:0] OFS_CTRL_SEC = 2'h1;
  localparam logic [1:0] OFS_RES_HIGH = 2'h2;
  localparam logic [1:0] OFS_RES_LOW = 2'h3;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int POS_ENABLE = 0;
  localparam int POS_RUN = 1;
  localparam int POS_CHAN_LO = 2;
  localparam int POS_CHAN_HI = 5;
  localparam int POS_CLKSEL_LO = 6;
  localparam int POS_CLKSEL_HI = 7;
  localparam int POS_POSREF = 4;
  localparam int POS_NEGREF = 5;
  localparam int POS_JUSTIFY = 7;

  // ----------------------------------------------------------------
  // reset values and field codes
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_CTRL_PRI = 8'h00;
  localparam logic [7:0] RST_CTRL_SEC = 8'h00;
  localparam logic [7:0] SEC_WRITE_MASK = 8'hB0;
  localparam logic [1:0] CLK_DIV2 = 2'h0;
  localparam logic [1:0] CLK_DIV8 = 2'h1;
  localparam logic [1:0] CLK_DIV32 = 2'h2;
  localparam logic [1:0] CLK_RC = 2'h3;
  localparam logic [3:0] CHAN_LAST_PIN = 4'hD;
  localparam logic [3:0] CHAN_CMP_REF = 4'hE;
  localparam logic [3:0] CHAN_FIXED_REF = 4'hF;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CONV_BIT_PERIODS = 11;
  localparam int ABORT_BIT_PERIODS = 2;
  localparam int SYS_DIV2 = 2;
  localparam int SYS_DIV8 = 8;
  localparam int SYS_DIV32 = 32;
  localparam int RC_FREQ_KHZ = 500;
  localparam int CORE_FREQ_KHZ = 200000;
  // rc bit period in core cycles, longest time rounds down
  localparam int RC_DIV = CORE_FREQ_KHZ / RC_FREQ_KHZ;
  // one instruction cycle delay before an rc conversion
  localparam int INSTR_CYCLES = 4;

  typedef enum {ST_IDLE, ST_RC_WAIT, ST_CONVERT, ST_ABORT} adcctl_state_t;
endpackage : adcctl_pkg

/* File: src/adcctl_top.sv */
/*
  Converter control and result registers: conversion clock select,
  channel and reference select, enable, run flag, and justified result.
  Assumes a CPU register port with one-cycle strobes, read data one
  cycle later, and an external successive approximation core that
  returns each bit through SAR_BIT in the period after a SAR_ACTIVE pulse.
*/
module adcctl_top
  import adcctl_pkg::*;
#(
  parameter int RC_DIVIDE = RC_DIV,
  parameter int RC_DELAY = INSTR_CYCLES
) (
  input wire logic CORE_CLK, // core clock, 200 MHz
  input wire logic RSTN, // asynchronous reset, active low
  input wire logic [1:0] ADDR, // register index
  input wire logic [7:0] WDATA, // write data
  input wire logic WR, // write strobe
  input wire logic RD, // read strobe
  output logic [7:0] RDATA, // read data, cycle after strobe
  input wire logic SAR_BIT, // comparator decision from the core
  output logic [3:0] INPUT_SEL, // channel routed to the sampler
  output logic CONV_POWER, // converter powered
  output logic POS_REF_PIN, // positive ref from pin, else supply
  output logic NEG_REF_PIN, // negative ref from pin, else ground
  output logic SAMPLE_HOLD, // high: hold, low: acquire
  output logic SAR_ACTIVE, // bit period tick to the core
  output logic DONE_PULSE // conversion done event, one cycle
);
  initial begin
    if (RC_DELAY < 1 || RC_DELAY > 255) begin
      $error("rc delay out of range");
    end
  end

  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  logic rst_meta_q, rst_n;

  // two-stage release so the design leaves reset on a clean edge
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  adcctl_state_t state_q, state_d;
  logic [7:0] pri_q, pri_d;
  logic [7:0] sec_q, sec_d;
  logic [7:0] res_high_q, res_high_d;
  logic [7:0] res_low_q, res_low_d;
  logic [9:0] shift_q, shift_d;
  logic [3:0] bits_q, bits_d;
  logic [7:0] wait_q, wait_d;
  logic [7:0] rdata_q, rdata_d;
  logic [3:0] sel_q;
  logic power_q, posref_q, negref_q, hold_q, active_q, done_q;
  logic tick;
  logic [7:0] fmt_high, fmt_low;
  logic wr_pri, wr_sec, wr_high, wr_low;
  logic enable, run_flag, rc_sel, start_req, abort_req;
  logic last_bit, finish;
  logic [1:0] clk_sel;

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  assign wr_pri = WR && (ADDR == OFS_CTRL_PRI);
  assign wr_sec = WR && (ADDR == OFS_CTRL_SEC);
  assign wr_high = WR && (ADDR == OFS_RES_HIGH);
  assign wr_low = WR && (ADDR == OFS_RES_LOW);

  // ------------------------------------------------------------
  // control fields
  // ------------------------------------------------------------
  assign enable = pri_q[POS_ENABLE];
  assign run_flag = pri_q[POS_RUN];
  assign clk_sel = pri_q[POS_CLKSEL_HI:POS_CLKSEL_LO];
  assign rc_sel = (clk_sel == CLK_RC);
  // a start needs the enable set in the same write; an enable already set is not enough
  assign start_req = wr_pri && WDATA[POS_RUN] && !run_flag &&
                     WDATA[POS_ENABLE];
  // clearing the flag or the enable mid-conversion aborts it
  assign abort_req = wr_pri && run_flag &&
                     (!WDATA[POS_RUN] || !WDATA[POS_ENABLE]);
  assign last_bit = (bits_q == 4'(CONV_BIT_PERIODS - 1));
  assign finish = (state_q == ST_CONVERT) && tick && last_bit;

  // ------------------------------------------------------------
  // bit period generator and result formatter
  // ------------------------------------------------------------
  adcctl_clkgen #(
    .RC_DIVIDE(RC_DIVIDE)
  ) u_clkgen (
    .clk(CORE_CLK),
    .rst_n(rst_n),
    .run(state_q == ST_CONVERT || state_q == ST_ABORT),
    .sel(clk_sel),
    .tick(tick)
  );

  adcctl_format u_format (
    .result(shift_d),
    .right_just(sec_q[POS_JUSTIFY]),
    .high_byte(fmt_high),
    .low_byte(fmt_low)
  );

  // ------------------------------------------------------------
  // sequencer next state
  // ------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    bits_d = bits_q;
    wait_d = wait_q;
    shift_d = shift_q;
    case (state_q)
      ST_IDLE: begin
        if (start_req) begin
          bits_d = 4'h0;
          shift_d = 10'h000;
          if (rc_sel) begin
            wait_d = 8'(RC_DELAY - 1);
            state_d = ST_RC_WAIT;
          end else begin
            state_d = ST_CONVERT;
          end
        end
      end
      ST_RC_WAIT: begin
        if (abort_req) begin
          state_d = ST_IDLE;
        end else if (wait_q == 8'h00) begin
          state_d = ST_CONVERT;
        end else begin
          wait_d = wait_q - 8'h01;
        end
      end
      ST_CONVERT: begin
        if (abort_req) begin
          bits_d = 4'h0;
          state_d = ST_ABORT;
        end else if (tick) begin
          // first period samples, the rest shift in one decision each
          if (bits_q != 4'h0) begin
            shift_d = {shift_q[8:0], SAR_BIT};
          end
          bits_d = bits_q + 4'h1;
          if (last_bit) begin
            state_d = ST_IDLE;
          end
        end
      end
      ST_ABORT: begin
        // two ticks of quiet, the first ending the bit period under way (the divider is not restarted), then acquisition resumes
        if (tick) begin
          bits_d = bits_q + 4'h1;
          if (bits_q == 4'(ABORT_BIT_PERIODS - 1)) begin
            state_d = ST_IDLE;
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // ------------------------------------------------------------
  // register next values
  // ------------------------------------------------------------
  // hardware clear of the run flag on finish; any write to the register wins
  assign pri_d = wr_pri ? {WDATA[7:2], start_req, WDATA[POS_ENABLE]} :
                 finish ? (pri_q & 8'hFD) : pri_q;
  assign sec_d = wr_sec ? (WDATA & SEC_WRITE_MASK) : sec_q;
  // completion loads both bytes on the same edge and beats a write
  assign res_high_d = finish ? fmt_high :
                      wr_high ? WDATA : res_high_q;
  assign res_low_d = finish ? fmt_low :
                     wr_low ? WDATA : res_low_q;
  assign rdata_d = !RD ? 8'h00 :
                   (ADDR == OFS_CTRL_PRI) ? pri_q :
                   (ADDR == OFS_CTRL_SEC) ? sec_q :
                   (ADDR == OFS_RES_HIGH) ? res_high_q :
                   res_low_q;

  // ------------------------------------------------------------
  // sequencer and register state
  // ------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      bits_q <= 4'h0;
      wait_q <= 8'h00;
      shift_q <= 10'h000;
      pri_q <= RST_CTRL_PRI;
      sec_q <= RST_CTRL_SEC;
      res_high_q <= 8'h00;
      res_low_q <= 8'h00;
      rdata_q <= 8'h00;
    end else begin
      state_q <= state_d;
      bits_q <= bits_d;
      wait_q <= wait_d;
      shift_q <= shift_d;
      pri_q <= pri_d;
      sec_q <= sec_d;
      res_high_q <= res_high_d;
      res_low_q <= res_low_d;
      rdata_q <= rdata_d;
    end
  end

  // ------------------------------------------------------------
  // analog side outputs, registered
  // ------------------------------------------------------------
  // hold is released only to acquire; the capacitor is never dumped
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      sel_q <= 4'h0;
      power_q <= 1'b0;
      posref_q <= 1'b0;
      negref_q <= 1'b0;
      hold_q <= 1'b0;
      active_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      sel_q <= pri_d[POS_CHAN_HI:POS_CHAN_LO];
      power_q <= pri_d[POS_ENABLE];
      posref_q <= sec_d[POS_POSREF];
      negref_q <= sec_d[POS_NEGREF];
      hold_q <= (state_d == ST_CONVERT) || (state_d == ST_ABORT);
      active_q <= (state_q == ST_CONVERT) && tick && !abort_req;
      done_q <= finish;
    end
  end

  assign RDATA = rdata_q;
  assign INPUT_SEL = sel_q;
  assign CONV_POWER = power_q;
  assign POS_REF_PIN = posref_q;
  assign NEG_REF_PIN = negref_q;
  assign SAMPLE_HOLD = hold_q;
  assign SAR_ACTIVE = active_q;
  assign DONE_PULSE = done_q;
endmodule // adcctl_top

/* File: tb/adcctl_sar_model.sv */
/*
  Model of the approximation core: returns a preset value msb first,
  one decision after each bit period pulse.
  Assumes hold stays high for the whole conversion.
*/
module adcctl_sar_model (
  input wire logic clk, // core clock
  input wire logic hold, // high while converting
  input wire logic tick, // bit period pulse
  input wire logic [9:0] value, // value to return
  output logic bit_out // comparator decision
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // decisions
  // ----------------------------------------------------------------
  int cnt = 0;
  initial bit_out = 1'b0;
  // outside the ten decisions the line toggles, so a stale level
  // can never pass for a real decision
  always @(negedge clk) begin
    if (!hold)
      cnt = 0;
    else if (tick)
      cnt = cnt + 1;
    if (cnt >= 1 && cnt <= 10)
      bit_out <= value[10-cnt];
    else
      bit_out <= ~bit_out;
  end
endmodule // adcctl_sar_model

/* File: tb/adcctl_sva.sv */
/*
  Checker for the converter control block, watching its top ports.
  Assumes one core clock domain and the active-low reset port.
*/
module adcctl_sva
  import adcctl_pkg::*;
#(
  parameter int RC_DIVIDE = RC_DIV,
  parameter int RC_DELAY = INSTR_CYCLES
) (
  input wire logic CORE_CLK, // core clock
  input wire logic RSTN, // reset, active low
  input wire logic [1:0] ADDR, // register index
  input wire logic [7:0] WDATA, // write data
  input wire logic WR, // write strobe
  input wire logic RD, // read strobe
  input wire logic [7:0] RDATA, // read data
  input wire logic SAR_BIT, // core decision
  input wire logic [3:0] INPUT_SEL, // routed channel
  input wire logic CONV_POWER, // converter powered
  input wire logic POS_REF_PIN, // positive ref source
  input wire logic NEG_REF_PIN, // negative ref source
  input wire logic SAMPLE_HOLD, // hold or acquire
  input wire logic SAR_ACTIVE, // bit period pulse
  input wire logic DONE_PULSE // completion event
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);

  // rc starts excluded: their hold level during the extra delay is open
  sequence s_start;
    WR && ADDR == OFS_CTRL_PRI && WDATA[1:0] == 2'b11 && !SAMPLE_HOLD
      && WDATA[7:6] != CLK_RC;
  endsequence
  sequence s_dead_start;
    WR && ADDR == OFS_CTRL_PRI && WDATA[1:0] == 2'b10 && !SAMPLE_HOLD;
  endsequence

  a_rdata_idle_zero: assert property (!$past(RD) |-> RDATA == 8'h00)
    else $error("read data not zero outside read cycle");
  a_enable_power: assert property (
    WR && ADDR == OFS_CTRL_PRI |=> CONV_POWER == $past(WDATA[POS_ENABLE]))
    else $error("power does not follow enable bit");
  a_chan_route: assert property (
    WR && ADDR == OFS_CTRL_PRI |=> INPUT_SEL == $past(WDATA[5:2]))
    else $error("routed channel differs from code");
  a_refs_follow: assert property (
    WR && ADDR == OFS_CTRL_SEC |=> POS_REF_PIN == $past(WDATA[4])
      && NEG_REF_PIN == $past(WDATA[5]))
    else $error("reference source differs from bits");
  a_start_holds: assert property (s_start |=> SAMPLE_HOLD [*8])
    else $error("start did not hold the sample");
  a_dead_start: assert property (
    s_dead_start |=> (!SAMPLE_HOLD && !SAR_ACTIVE) [*4])
    else $error("conversion began while disabled");
  a_done_single: assert property (DONE_PULSE |=> !DONE_PULSE)
    else $error("done event longer than one cycle");
  a_done_acquire: assert property (
    DONE_PULSE |-> !SAMPLE_HOLD && $past(SAMPLE_HOLD))
    else $error("done event without end of hold");
  a_tick_single: assert property (SAR_ACTIVE |=> !SAR_ACTIVE)
    else $error("bit period pulse longer than one cycle");
endmodule // adcctl_sva

bind adcctl_top adcctl_sva #(.RC_DIVIDE(RC_DIVIDE), .RC_DELAY(RC_DELAY))
  u_sva (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA),
  .WR(WR), .RD(RD), .RDATA(RDATA), .SAR_BIT(SAR_BIT),
  .INPUT_SEL(INPUT_SEL), .CONV_POWER(CONV_POWER),
  .POS_REF_PIN(POS_REF_PIN), .NEG_REF_PIN(NEG_REF_PIN),
  .SAMPLE_HOLD(SAMPLE_HOLD), .SAR_ACTIVE(SAR_ACTIVE),
  .DONE_PULSE(DONE_PULSE));

/* File: tb/adcctl_top_tb.sv */
/*
  Testbench of the converter control block: register accesses on the
  strobe port and whole conversions against the core model.
  Assumes the register indexes and fields of the package.
*/
module adcctl_top_tb
  import adcctl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // bench
  // ----------------------------------------------------------------
  localparam int TB_RC = 20;
  logic clk = 0, rst_n = 0, wr_s = 0, rd_s = 0, sar_bit;
  logic [1:0] addr = '0;
  logic [7:0] wdata = '0, rdata, d, eh, el;
  logic [3:0] in_sel;
  logic power, pos_pin, neg_pin, hold, tick, done;
  logic [9:0] val = '0;
  int failures = 0, checks_done = 0, cyc = 0;
  int pulses = 0, last_t = 0, per = 0, dones = 0, gap_bad = 0;

  adcctl_top #(.RC_DIVIDE(TB_RC), .RC_DELAY(INSTR_CYCLES)) uut (
    .CORE_CLK(clk), .RSTN(rst_n), .ADDR(addr), .WDATA(wdata),
    .WR(wr_s), .RD(rd_s), .RDATA(rdata), .SAR_BIT(sar_bit),
    .INPUT_SEL(in_sel), .CONV_POWER(power), .POS_REF_PIN(pos_pin),
    .NEG_REF_PIN(neg_pin), .SAMPLE_HOLD(hold), .SAR_ACTIVE(tick),
    .DONE_PULSE(done));
  adcctl_sar_model sar (.clk(clk), .hold(hold), .tick(tick),
    .value(val), .bit_out(sar_bit));

  // 200 MHz core clock
  always #2.5 clk = ~clk;

  // cycle count and hang limit, far above the longest run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      finish_test();
    end
  end

  // pulse spacing and done events, sampled away from the edge
  always @(negedge clk) begin
    if (tick === 1'b1) begin
      if (pulses > 0 && cyc - last_t != per)
        gap_bad++;
      pulses++;
      last_t = cyc;
    end
    if (done === 1'b1)
      dones++;
  end

  task automatic finish_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(string n, logic [9:0] e, logic [9:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask

  // the write strobe is left up so accesses may follow with no gap
  task automatic wr(logic [1:0] a, logic [7:0] v);
    rd_s <= 1'b0;
    addr <= a;
    wdata <= v;
    wr_s <= 1'b1;
    @(posedge clk);
  endtask

  task automatic rd(logic [1:0] a, output logic [7:0] v);
    wr_s <= 1'b0;
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(posedge clk);
    v = rdata;
  endtask

  task automatic nop(int n);
    wr_s <= 1'b0;
    rd_s <= 1'b0;
    repeat (n) @(posedge clk);
  endtask

  // one whole conversion and the formatted result
  task automatic conv(logic [1:0] cs, logic rj, logic [9:0] v, int p);
    val = v;
    per = p;
    wr(OFS_CTRL_SEC, {rj, 7'h00});
    wr(OFS_CTRL_PRI, {cs, 6'h01});
    nop(30);
    pulses = 0;
    gap_bad = 0;
    dones = 0;
    wr(OFS_CTRL_PRI, {cs, 6'h03});
    rd(OFS_CTRL_PRI, d);
    chk("run_busy", 10'h001, 10'(d[POS_RUN]));
    for (int t = 0; t < 3000 && dones == 0; t++) @(posedge clk);
    chk("done", 10'h001, 10'(dones));
    chk("ticks", 10'd11, 10'(pulses));
    chk("tick_gap", 10'h000, 10'(gap_bad));
    rd(OFS_CTRL_PRI, d);
    chk("run_clear", 10'h000, 10'(d[POS_RUN]));
    rd(OFS_RES_HIGH, eh);
    rd(OFS_RES_LOW, el);
    if (rj) begin
      chk("hi_right", 10'(v[9:8]), 10'(eh[1:0]));
      chk("lo_right", 10'(v[7:0]), 10'(el));
    end else begin
      chk("hi_left", 10'(v[9:2]), 10'(eh));
      chk("lo_left", 10'(v[1:0]), 10'(el[7:6]));
    end
  endtask

  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    nop(5);
    rd(OFS_CTRL_PRI, d);
    chk("pri_reset", 10'(RST_CTRL_PRI), 10'(d));
    rd(OFS_CTRL_SEC, d);
    chk("sec_reset", 10'(RST_CTRL_SEC), 10'(d));
    wr(OFS_CTRL_SEC, 8'hFF);
    rd(OFS_CTRL_SEC, d);
    chk("sec_mask", 10'(SEC_WRITE_MASK), 10'(d));
    chk("ref_pins", 10'h003, 10'({pos_pin, neg_pin}));
    for (int c = 0; c < 16; c++) begin
      wr(OFS_CTRL_PRI, {2'b00, 4'(c), 2'b00});
      nop(1);
      chk("chan", 10'(c), 10'(in_sel));
    end
    wr(OFS_CTRL_PRI, 8'h02);
    nop(6);
    rd(OFS_CTRL_PRI, d);
    chk("dead_run", 10'h000, 10'({d[POS_RUN], hold, power}));
    wr(OFS_RES_HIGH, 8'h5A);
    wr(OFS_RES_LOW, 8'hA5);
    rd(OFS_RES_HIGH, eh);
    chk("res_hi_rw", 10'h05A, 10'(eh));
    rd(OFS_RES_LOW, el);
    chk("res_lo_rw", 10'h0A5, 10'(el));
    conv(CLK_DIV2, 1'b1, 10'h2A5, SYS_DIV2);
    conv(CLK_DIV32, 1'b0, 10'h15A, SYS_DIV32);
    conv(CLK_RC, 1'b0, 10'h0C3, TB_RC);
    conv(CLK_DIV8, 1'b1, 10'h2C5, SYS_DIV8);
    // abort mid conversion: result kept, hold ends on the second bit period tick after the abort
    val = 10'h13C;
    dones = 0;
    wr(OFS_CTRL_PRI, 8'h43);
    nop(40);
    wr(OFS_CTRL_PRI, 8'h41);
    nop(8);
    chk("abort_hold", 10'h001, 10'(hold));
    for (int t = 0; t < 20 && hold !== 1'b0; t++) @(posedge clk);
    chk("abort_free", 10'h000, 10'(hold));
    rd(OFS_RES_LOW, el);
    chk("abort_keep", 10'h0C5, 10'(el));
    chk("abort_done", 10'h000, 10'(dones));
    conv(CLK_DIV8, 1'b0, 10'h3FF, SYS_DIV8);
    finish_test();
  end
endmodule // adcctl_top_tb
